// [inc/pbc_defines.svh]
// Register map, field positions, reset values and switch timing of the loop
// clock controller. Assumes a 32-bit APB slave with byte addresses.
`ifndef PBC_DEFINES_SVH
`define PBC_DEFINES_SVH

`define PBC_OFS_CONTROL    8'h00
`define PBC_OFS_BANDWIDTH  8'h04
`define PBC_OFS_PROGRAM    8'h08

`define PBC_CTL_IRQ_EN     7
`define PBC_CTL_FLAG       6
`define PBC_CTL_LOOP_ON    5
`define PBC_CTL_BASE_SEL   4
`define PBC_CTL_UNUSED     4'hF

`define PBC_BW_AUTO        7
`define PBC_BW_LOCK        6

`define PBC_PRG_MUL_HI     7
`define PBC_PRG_MUL_LO     4
`define PBC_PRG_RNG_HI     3
`define PBC_PRG_RNG_LO     0

`define PBC_RST_MUL        4'h6
`define PBC_RST_RANGE      4'h6
`define PBC_MUL_ONE        4'h1
`define PBC_SWITCH_EDGES   3

`endif

// [inc/pbc_pkg.sv]
// Types shared by the loop clock controller.
// Assumes pbc_defines.svh supplies the numeric constants.
package pbc_pkg;

    typedef enum logic [0:0] {
        PBC_RUN,
        PBC_SWITCH
    } pbc_state_e;

endpackage

// [logic/pbc_clock_selector.sv]
// Loop clock control: programming fields, loop/select interlocks, lock flag,
// and glitch-free base clock selection with divide-by-two output.
// Assumes crystal and VCO clocks arrive as inputs synchronous to clock,
// each well below half the 200 MHz system rate.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "pbc_defines.svh"

// Functional notes
// (RQ1) A zero multiplier field drives the feedback divider as one.
// (RQ2) Zero range factor keeps the loop disabled and VCO unselectable.
// (RQ3) Zero range factor forces the crystal clock as base source.
// (RQ4) Multiplier lives in programming register bits 7 to 4, binary.
// (RQ5) Range factor lives in programming register bits 3 to 0, binary.
// (RQ6) Source change waits three crystal and three VCO edges, output frozen.
// (RQ7) Selected clock is divided by two after the transition control.
// (RQ8) Base clock output has 50% duty, half the selected clock rate.
// (RQ9) Base select bit: one picks VCO clock, zero picks crystal clock.
// (RQ10) VCO cannot be selected while the loop-on bit is clear.
// (RQ11) Loop-on cannot be cleared while the VCO is selected.
// (RQ12) Each interlock is judged against prior state; two writes needed.
// (RQ13) Enabled lock-change flag raises the CPU interrupt request.
// (RQ14) Lock interrupt enable ignores writes, reads zero, when auto off.
// (RQ15) Reset clears the lock interrupt enable.
// (RQ16) Oscillator enable input gates both crystal oscillator and loop.
// (RQ17) Interrupt output comes from lock-change flag qualified by enable.
// (RQ18) Lock flag sets on every lock toggle, clears on control read. Code sets it only on toggles in auto bandwidth mode.
// (RQ19) Reset and stop request clear the base select bit.
// (RQ20) Reset sets the loop-on bit.
// (RQ21) Multiplier and range fields ignore writes while loop is on.
// (RQ22) Lock indication and VCO clock come in from the analog loop.
// (RQ23) Outgoing clock stops low before the incoming one is released.
module pbc_clock_selector
    import pbc_pkg::*;
#(
    parameter int ADDR_W       = 8,
    parameter int SWITCH_EDGES = `PBC_SWITCH_EDGES
) (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              crystalClock,
    input  wire logic              vcoClock,
    input  wire logic              lockIn,
    input  wire logic              oscEnableIn,
    input  wire logic              stopReq,
    output logic                   baseClockOut,
    output logic                   oscRun,
    output logic                   loopRun,
    output logic      [3:0]        feedbackDiv,
    output logic      [3:0]        rangeFactor,
    output logic                   vcoActive,
    output logic                   clockgenIrq
);

    // Two-bit edge counters and a four-bit offset decode bound these values
    if (SWITCH_EDGES < 1 || SWITCH_EDGES > 3 || ADDR_W < 4) begin : g_bad_params
        $error("pbc_clock_selector: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        irqEn_q;
    logic        lockFlag_q;
    logic        loopOn_q;
    logic        baseSel_q;
    logic        autoBw_q;
    logic        lockPrev_q;
    logic [3:0]  mul_q;
    logic [3:0]  range_q;

    logic        access;
    logic        wrCtrl;
    logic        wrBw;
    logic        wrProg;
    logic        rdCtrl;
    logic        mapped;
    logic        lockToggle;
    logic [7:0]  ctrlView;
    logic [7:0]  bwView;

    assign access     = psel && penable && pready_q;
    assign mapped     = paddr == ADDR_W'(`PBC_OFS_CONTROL) ||
                        paddr == ADDR_W'(`PBC_OFS_BANDWIDTH) ||
                        paddr == ADDR_W'(`PBC_OFS_PROGRAM);
    assign wrCtrl     = access && pwrite && paddr == ADDR_W'(`PBC_OFS_CONTROL);
    assign wrBw       = access && pwrite && paddr == ADDR_W'(`PBC_OFS_BANDWIDTH);
    assign wrProg     = access && pwrite && paddr == ADDR_W'(`PBC_OFS_PROGRAM);
    assign rdCtrl     = access && !pwrite && paddr == ADDR_W'(`PBC_OFS_CONTROL);
    assign lockToggle = autoBw_q && (lockIn != lockPrev_q);

    // Flag and enable read as zero in manual bandwidth mode
    always_comb begin
        ctrlView                    = {4'h0, `PBC_CTL_UNUSED};
        ctrlView[`PBC_CTL_IRQ_EN]   = irqEn_q && autoBw_q;  // see (RQ14)
        ctrlView[`PBC_CTL_FLAG]     = lockFlag_q && autoBw_q;
        ctrlView[`PBC_CTL_LOOP_ON]  = loopOn_q;
        ctrlView[`PBC_CTL_BASE_SEL] = baseSel_q;
        bwView                      = 8'h00;
        bwView[`PBC_BW_AUTO]        = autoBw_q;
        bwView[`PBC_BW_LOCK]        = autoBw_q && lockIn;
    end

    // Ready from the first cycle of the access phase, data registered alongside
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel && !penable && !pready_q;
            pslverr_q <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                if (paddr == ADDR_W'(`PBC_OFS_CONTROL)) begin
                    prdata_q <= {24'h00_0000, ctrlView};
                end else if (paddr == ADDR_W'(`PBC_OFS_BANDWIDTH)) begin
                    prdata_q <= {24'h00_0000, bwView};
                end else if (paddr == ADDR_W'(`PBC_OFS_PROGRAM)) begin
                    prdata_q <= {24'h00_0000, mul_q, range_q};  // see (RQ4) see (RQ5)
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register with interlocks

    // Interlocks use prior state, so one write cannot both start the loop and
    // pick the VCO, nor drop the VCO and stop the loop
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            loopOn_q  <= 1'b1;  // see (RQ20)
            baseSel_q <= 1'b0;  // see (RQ19)
        end else begin
            if (wrCtrl && !(baseSel_q && !pwdata[`PBC_CTL_LOOP_ON])) begin
                loopOn_q <= pwdata[`PBC_CTL_LOOP_ON];  // see (RQ11) see (RQ12)
            end
            if (stopReq || range_q == 4'h0) begin
                baseSel_q <= 1'b0;  // see (RQ3) see (RQ19)
            end else if (wrCtrl) begin
                baseSel_q <= pwdata[`PBC_CTL_BASE_SEL] && loopOn_q;  // see (RQ9) see (RQ10)
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqEn_q <= 1'b0;  // see (RQ15)
        end else if (!autoBw_q) begin
            irqEn_q <= 1'b0;  // see (RQ14)
        end else if (wrCtrl) begin
            irqEn_q <= pwdata[`PBC_CTL_IRQ_EN];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            autoBw_q <= 1'b0;
        end else if (wrBw) begin
            autoBw_q <= pwdata[`PBC_BW_AUTO];
        end
    end

    // A toggle in the same cycle as the clearing read wins; only a flag that
    // the read has reported is cleared, so a toggle after setup is kept
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lockPrev_q <= 1'b0;
            lockFlag_q <= 1'b0;
        end else begin
            lockPrev_q <= lockIn;  // see (RQ22)
            if (lockToggle) begin
                lockFlag_q <= 1'b1;  // see (RQ18)
            end else if ((rdCtrl && prdata_q[`PBC_CTL_FLAG]) || !autoBw_q) begin
                lockFlag_q <= 1'b0;  // see (RQ18)
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mul_q   <= `PBC_RST_MUL;
            range_q <= `PBC_RST_RANGE;
        end else if (wrProg && !loopOn_q) begin
            mul_q   <= pwdata[`PBC_PRG_MUL_HI:`PBC_PRG_MUL_LO];  // see (RQ4) see (RQ21)
            range_q <= pwdata[`PBC_PRG_RNG_HI:`PBC_PRG_RNG_LO];  // see (RQ5) see (RQ21)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Loop outputs and interrupt

    logic       oscRun_q;
    logic       loopRun_q;
    logic [3:0] feedbackDiv_q;
    logic       irq_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oscRun_q      <= 1'b0;
            loopRun_q     <= 1'b0;
            feedbackDiv_q <= `PBC_RST_MUL;
            irq_q         <= 1'b0;
        end else begin
            oscRun_q      <= oscEnableIn;  // see (RQ16)
            loopRun_q     <= oscEnableIn && loopOn_q && range_q != 4'h0;  // see (RQ2) see (RQ16)
            feedbackDiv_q <= (mul_q == 4'h0) ? `PBC_MUL_ONE : mul_q;  // see (RQ1)
            irq_q         <= lockFlag_q && irqEn_q && autoBw_q;  // see (RQ13) see (RQ17)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transition control and divide-by-two

    pbc_state_e state_q;
    logic       xPrev_q;
    logic       vPrev_q;
    logic [1:0] xCnt_q;
    logic [1:0] vCnt_q;
    logic       activeSel_q;
    logic       base_q;
    logic       xEdge;
    logic       vEdge;
    logic       selEdge;
    logic       xDone;
    logic       vDone;

    // A stopped source counts as done so a dead VCO cannot hang the switch
    assign xEdge   = oscRun_q && crystalClock && !xPrev_q;
    assign vEdge   = loopRun_q && vcoClock && !vPrev_q;
    assign selEdge = activeSel_q ? vEdge : xEdge;
    assign xDone   = xCnt_q == 2'(SWITCH_EDGES) || !oscRun_q;
    assign vDone   = vCnt_q == 2'(SWITCH_EDGES) || !loopRun_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            xPrev_q <= 1'b0;
            vPrev_q <= 1'b0;
        end else begin
            xPrev_q <= crystalClock;
            vPrev_q <= vcoClock;  // see (RQ22)
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q     <= PBC_RUN;
            activeSel_q <= 1'b0;
            xCnt_q      <= 2'h0;
            vCnt_q      <= 2'h0;
        end else begin
            unique case (state_q)
                PBC_RUN: begin
                    // Leave only once the output sits low, so no runt pulse
                    if (baseSel_q != activeSel_q && !base_q) begin
                        state_q <= PBC_SWITCH;  // see (RQ23)
                        xCnt_q  <= 2'h0;
                        vCnt_q  <= 2'h0;
                    end
                end
                PBC_SWITCH: begin
                    if (xEdge && !xDone) begin
                        xCnt_q <= xCnt_q + 2'h1;  // see (RQ6)
                    end
                    if (vEdge && !vDone) begin
                        vCnt_q <= vCnt_q + 2'h1;  // see (RQ6)
                    end
                    if (baseSel_q == activeSel_q) begin
                        state_q <= PBC_RUN;
                    end else if (xDone && vDone) begin
                        activeSel_q <= baseSel_q;  // see (RQ23)
                        state_q     <= PBC_RUN;
                    end
                end
            endcase
        end
    end

    // Toggling on each source rising edge gives half rate with 50% duty
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            base_q <= 1'b0;
        end else if (state_q == PBC_RUN && selEdge
                     && !(baseSel_q != activeSel_q && !base_q)) begin
            base_q <= !base_q;  // see (RQ7) see (RQ8)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign baseClockOut = base_q;
    assign oscRun       = oscRun_q;
    assign loopRun      = loopRun_q;
    assign feedbackDiv  = feedbackDiv_q;
    assign rangeFactor  = range_q;
    assign vcoActive    = activeSel_q;
    assign clockgenIrq  = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    mul_zero_one_a: assert property ( // see (RQ1)
        ##1 feedbackDiv_q == (($past(mul_q) == 4'h0) ? 4'h1 : $past(mul_q)))
        else $error("feedback divider does not follow multiplier");

    range_zero_off_a: assert property ( // see (RQ2)
        range_q == 4'h0 |=> !loopRun_q && !baseSel_q)
        else $error("loop or VCO active with zero range");

    range_zero_xtal_a: assert property ( // see (RQ3)
        range_q == 4'h0 && !activeSel_q |=> !activeSel_q)
        else $error("VCO taken with zero range");

    switch_frozen_a: assert property ( // see (RQ6)
        state_q == PBC_SWITCH |=> $stable(base_q))
        else $error("base clock moved during switch");

    switch_low_a: assert property ( // see (RQ23)
        $changed(activeSel_q) |-> !base_q)
        else $error("source changed while output high");

    base_on_edge_a: assert property ( // see (RQ7)
        $changed(base_q) |-> $past(selEdge) && $past(state_q) == PBC_RUN)
        else $error("base clock toggled without source edge");

    sel_needs_loop_a: assert property ( // see (RQ10)
        !loopOn_q |=> !baseSel_q)
        else $error("VCO selected with loop off");

    loop_held_a: assert property ( // see (RQ11)
        baseSel_q && loopOn_q |=> loopOn_q)
        else $error("loop cleared while VCO selected");

    irq_path_a: assert property ( // see (RQ17)
        ##1 clockgenIrq == $past(lockFlag_q && irqEn_q && autoBw_q))
        else $error("interrupt not tied to flag and enable");

    enable_manual_a: assert property ( // see (RQ14)
        !autoBw_q |=> !irqEn_q)
        else $error("interrupt enable held in manual mode");

    flag_set_a: assert property ( // see (RQ18)
        lockToggle |=> lockFlag_q)
        else $error("lock toggle lost");

    flag_clear_a: assert property ( // see (RQ18)
        rdCtrl && prdata_q[`PBC_CTL_FLAG] && !lockToggle |=> !lockFlag_q)
        else $error("control read did not clear flag");

    fields_locked_a: assert property ( // see (RQ21)
        loopOn_q |=> $stable(mul_q) && $stable(range_q))
        else $error("programming written while loop on");

    stop_clears_a: assert property ( // see (RQ19)
        stopReq |=> !baseSel_q)
        else $error("stop did not clear select");

    cov_to_vco_c: cover property (!activeSel_q ##1 activeSel_q);
    cov_to_xtal_c: cover property (activeSel_q ##1 !activeSel_q);
    cov_irq_c: cover property (!clockgenIrq ##1 clockgenIrq);
    cov_flag_race_c: cover property (lockToggle && rdCtrl);

endmodule

// [verification/pbc_testbench.sv]
// Self-checking bench for the loop clock controller: registers over APB,
// interlocks, lock interrupt and base clock rates.
// Assumes pbc_defines.svh on the include path and the design's own assertions.
`timescale 1ns/1ps
`include "pbc_defines.svh"

module testbench
    import pbc_pkg::*;
;
    logic        clock;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        crystalClock;
    logic        vcoClock;
    logic        lockIn;
    logic        oscEnableIn;
    logic        stopReq;
    logic        baseClockOut;
    logic        oscRun;
    logic        loopRun;
    logic [3:0]  feedbackDiv;
    logic [3:0]  rangeFactor;
    logic        vcoActive;
    logic        clockgenIrq;
    int          errors;
    int          nChecks;
    int          xCnt;
    int          vCnt;
    logic [31:0] rd;
    logic        er;

    pbc_clock_selector pbc_clock_selector_inst (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crystalClock(crystalClock),
        .vcoClock(vcoClock), .lockIn(lockIn), .oscEnableIn(oscEnableIn),
        .stopReq(stopReq), .baseClockOut(baseClockOut), .oscRun(oscRun),
        .loopRun(loopRun), .feedbackDiv(feedbackDiv), .rangeFactor(rangeFactor),
        .vcoActive(vcoActive), .clockgenIrq(clockgenIrq)
    );

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Sources are slow synchronous levels: crystal rises every 8, VCO every 6
    always @(posedge clock) begin
        xCnt <= (xCnt == 3) ? 0 : xCnt + 1;
        vCnt <= (vCnt == 2) ? 0 : vCnt + 1;
        if (xCnt == 3) crystalClock <= ~crystalClock;
        if (vCnt == 2) vcoClock <= ~vcoClock;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Pready is read before the edge's own updates land, as the master sees it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic waitVco(input logic v);
        int n;
        n = 0;
        while (vcoActive !== v && n < 200) begin
            @(posedge clock);
            n++;
        end
        chk("vcoActive", {31'h0, v}, {31'h0, vcoActive});
    endtask

    // Half period of the base clock in system cycles
    task automatic halves(input int half);
        int h;
        int l;
        h = 0;
        l = 0;
        while (baseClockOut !== 1'b0 && l < 200) begin @(posedge clock); l++; end
        l = 0;
        while (baseClockOut !== 1'b1 && l < 200) begin @(posedge clock); l++; end
        while (baseClockOut === 1'b1 && h < 200) begin @(posedge clock); h++; end
        l = 0;
        while (baseClockOut === 1'b0 && l < 200) begin @(posedge clock); l++; end
        chk("base high", half, h);
        chk("base low", half, l);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdchk("ctl", `PBC_OFS_CONTROL, 32'h2F);
        rdchk("prg", `PBC_OFS_PROGRAM, 32'h66);
        rdchk("bw", `PBC_OFS_BANDWIDTH, 32'h0);
        chk("div", 32'h6, {28'h0, feedbackDiv});
        chk("loopRun", 32'h1, {31'h0, loopRun});
        rdchk("unmapped", 8'h0C, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        $display("test reset done");
    endtask

    task automatic t_program;
        wr(`PBC_OFS_PROGRAM, 32'h11);
        rdchk("prg locked", `PBC_OFS_PROGRAM, 32'h66);
        wr(`PBC_OFS_CONTROL, 32'h00);
        rdchk("ctl off", `PBC_OFS_CONTROL, 32'h0F);
        chk("loopRun off", 32'h0, {31'h0, loopRun});
        wr(`PBC_OFS_PROGRAM, 32'h05);
        rdchk("prg", `PBC_OFS_PROGRAM, 32'h05);
        chk("div zero", 32'h1, {28'h0, feedbackDiv});
        wr(`PBC_OFS_PROGRAM, 32'h37);
        // Field lands at the access edge, the divider output one edge later
        repeat (2) @(posedge clock);
        chk("div", 32'h3, {28'h0, feedbackDiv});
        chk("range", 32'h7, {28'h0, rangeFactor});
        wr(8'h0C, 32'hFF);
        chk("pslverr wr", 32'h1, {31'h0, er});
        $display("test program done");
    endtask

    task automatic t_interlock;
        wr(`PBC_OFS_CONTROL, 32'h30);
        rdchk("sel refused", `PBC_OFS_CONTROL, 32'h2F);
        halves(8);
        wr(`PBC_OFS_CONTROL, 32'h30);
        rdchk("sel vco", `PBC_OFS_CONTROL, 32'h3F);
        waitVco(1'b1);
        halves(6);
        wr(`PBC_OFS_CONTROL, 32'h00);
        rdchk("off refused", `PBC_OFS_CONTROL, 32'h2F);
        waitVco(1'b0);
        $display("test interlock done");
    endtask

    task automatic t_range0;
        wr(`PBC_OFS_CONTROL, 32'h00);
        wr(`PBC_OFS_PROGRAM, 32'h30);
        wr(`PBC_OFS_CONTROL, 32'h20);
        wr(`PBC_OFS_CONTROL, 32'h30);
        rdchk("sel range0", `PBC_OFS_CONTROL, 32'h2F);
        chk("loopRun range0", 32'h0, {31'h0, loopRun});
        chk("vco range0", 32'h0, {31'h0, vcoActive});
        wr(`PBC_OFS_CONTROL, 32'h00);
        wr(`PBC_OFS_PROGRAM, 32'h37);
        wr(`PBC_OFS_CONTROL, 32'h20);
        wr(`PBC_OFS_CONTROL, 32'h30);
        waitVco(1'b1);
        @(posedge clock);
        stopReq <= 1'b1;
        @(posedge clock);
        stopReq <= 1'b0;
        rdchk("sel stop", `PBC_OFS_CONTROL, 32'h2F);
        waitVco(1'b0);
        $display("test range done");
    endtask

    task automatic t_irq;
        int n;
        wr(`PBC_OFS_CONTROL, 32'hA0);
        rdchk("ie manual", `PBC_OFS_CONTROL, 32'h2F);
        wr(`PBC_OFS_BANDWIDTH, 32'h80);
        wr(`PBC_OFS_CONTROL, 32'hA0);
        rdchk("ie auto", `PBC_OFS_CONTROL, 32'hAF);
        lockIn <= 1'b1;
        n = 0;
        while (clockgenIrq !== 1'b1 && n < 10) begin @(posedge clock); n++; end
        chk("irq", 32'h1, {31'h0, clockgenIrq});
        rdchk("flag set", `PBC_OFS_CONTROL, 32'hEF);
        rdchk("flag clr", `PBC_OFS_CONTROL, 32'hAF);
        chk("irq clr", 32'h0, {31'h0, clockgenIrq});
        rdchk("bw lock", `PBC_OFS_BANDWIDTH, 32'hC0);
        wr(`PBC_OFS_CONTROL, 32'h20);
        lockIn <= 1'b0;
        repeat (5) @(posedge clock);
        chk("irq masked", 32'h0, {31'h0, clockgenIrq});
        rdchk("flag fall", `PBC_OFS_CONTROL, 32'h6F);
        $display("test irq done");
    endtask

    task automatic t_osc;
        @(posedge clock);
        oscEnableIn <= 1'b0;
        repeat (3) @(posedge clock);
        chk("oscRun", 32'h0, {31'h0, oscRun});
        chk("loopRun", 32'h0, {31'h0, loopRun});
        oscEnableIn <= 1'b1;
        repeat (3) @(posedge clock);
        chk("oscRun on", 32'h1, {31'h0, oscRun});
        chk("loopRun on", 32'h1, {31'h0, loopRun});
        $display("test osc done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The whole sequence needs a few hundred cycles
    initial begin
        #200000;
        errors++;
        summarize();
    end

    initial begin
        errors = 0; nChecks = 0; xCnt = 0; vCnt = 0;
        sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; crystalClock = 1'b0; vcoClock = 1'b0;
        lockIn = 1'b0; oscEnableIn = 1'b1; stopReq = 1'b0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_program();
        t_interlock();
        t_range0();
        t_irq();
        t_osc();
        summarize();
    end
endmodule
